//--- prt_host_model.sv
// Host model that receives pixel rows and measures every frame it is sent.
`timescale 1ns/1ps
module prt_host_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Pixel stream
  input  wire logic              frame_start,
  input  wire logic              frame_valid,
  input  wire logic              line_valid,
  input  wire prt_pkg::prt_pos_t pos,
  // Results of the last finished frame
  output logic [15:0]            lines_seen,
  output logic [15:0]            pix_seen,
  output prt_pkg::prt_pos_t      first_pos,
  output prt_pkg::prt_pos_t      last_pos,
  output logic [31:0]            period,
  output logic [31:0]            fv_len
);
  import prt_pkg::*;
  // ==========================================================================
  // Frame measurement
  logic [15:0] ln_r;
  logic [15:0] px_r;
  logic [31:0] cyc_r;
  logic [31:0] fvc_r;
  logic        lv_r;
  prt_pos_t    f_r;
  prt_pos_t    l_r;
  // The host accepts every pixel it is offered and never stalls a row.
  // A slowed tick holds a pixel for several cycles, so it counts once per new column.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {ln_r, px_r, cyc_r, fvc_r, lv_r, f_r, l_r} <= '0;
      {lines_seen, pix_seen, period, fv_len, first_pos, last_pos} <= '0;
    end else if (frame_start) begin
      {lines_seen, pix_seen, period, fv_len} <= {ln_r, px_r, cyc_r, fvc_r};
      first_pos <= f_r;
      last_pos <= l_r;
      {ln_r, px_r, lv_r} <= '0;
      fvc_r <= '0;
      cyc_r <= 32'h0000_0001;
    end else begin
      cyc_r <= cyc_r + 32'h0000_0001;
      lv_r <= line_valid;
      if (frame_valid) fvc_r <= fvc_r + 32'h0000_0001;
      if (line_valid) begin
        if (!lv_r || pos.col != l_r.col) px_r <= px_r + 16'h0001;
        l_r <= pos;
        if (!lv_r) begin
          ln_r <= ln_r + 16'h0001;
          if (ln_r == 16'h0000) f_r <= pos;
        end
      end
    end
  end
endmodule

//--- prt_pkg.sv
// Shared constants, types and lookup tables of the pixel array readout timing block.
package prt_pkg;

  // ==========================================================================
  // Window defaults and array limits
  localparam logic [11:0] PRT_DEF_X_START = 12'h0008;
  localparam logic [11:0] PRT_DEF_Y_START = 12'h0008;
  localparam logic [11:0] PRT_DEF_X_OUT   = 12'h0F00;
  localparam logic [11:0] PRT_DEF_Y_OUT   = 12'h0ABC;
  localparam logic [3:0]  PRT_BORDER_MAX  = 4'h8;
  localparam logic [3:0]  PRT_BORDER_BIN  = 4'h4;
  localparam logic [1:0]  PRT_SKIPX_LOG_MAX = 2'h2;
  localparam logic [2:0]  PRT_SKIPY_LOG_MAX = 3'h5;
  localparam logic [2:0]  PRT_BINXY_SKIPY_LOG_MAX = 3'h2;
  localparam logic [2:0]  PRT_ILLEGAL_LP_DIV = 3'h4;
  localparam logic [11:0] PRT_PAIR_NEAR = 12'h0002;
  localparam logic [11:0] PRT_PAIR_FAR  = 12'h0004;
  // Colour phase of the array origin; the value is arbitrary.
  localparam logic [1:0]  PRT_BAYER_BASE = 2'h0;

  // ==========================================================================
  // Frame limits
  localparam logic [15:0] PRT_MIN_FRAME_BLANK = 16'h008F;
  localparam logic [15:0] PRT_MIN_FRAME_LINES = 16'h0091;
  localparam logic [15:0] PRT_FIFO_LINE_PAD   = 16'h005E;

  // ==========================================================================
  // Speed tables: index 0..2 is speed 1/2/4 unbinned, 3..5 the same with row binning
  localparam logic [15:0] PRT_MIN_BLANK_TBL [0:5] =
    '{16'h046E, 16'h029A, 16'h01B0, 16'h0822, 16'h046C, 16'h0292};
  localparam logic [15:0] PRT_MIN_LINE_TBL [0:5] =
    '{16'h0670, 16'h03E0, 16'h02F0, 16'h0CC0, 16'h0660, 16'h03D8};
  localparam logic [15:0] PRT_FINE_MIN_TBL [0:5] =
    '{16'h03F2, 16'h020A, 16'h0094, 16'h07B2, 16'h03AE, 16'h010C};
  localparam logic [15:0] PRT_FINE_MARGIN_TBL [0:5] =
    '{16'h027E, 16'h012E, 16'h0108, 16'h050E, 16'h0276, 16'h0224};
  localparam logic [15:0] PRT_FINE_CORR_TBL [0:5] =
    '{16'h009C, 16'h0048, 16'h001E, 16'h0134, 16'h0094, 16'h0044};

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [11:0] x_start;
    logic [11:0] y_start;
    logic [11:0] x_end;
    logic [11:0] y_end;
    logic [11:0] x_out;
    logic [11:0] y_out;
    logic        mirror;
    logic        flip;
    logic [1:0]  skip_x_log;
    logic [2:0]  skip_y_log;
    logic        bin_x;
    logic        two_axis_average;
    logic        sum_x;
    logic        sum_xy;
    logic        bin_spread;
    logic [2:0]  row_speed;
    logic [2:0]  pixel_clock_divider;
    logic        low_power;
    logic [15:0] line_len;
    logic [15:0] frame_len;
    logic [15:0] coarse;
  } prt_cfg_t;

  typedef struct packed {
    logic [11:0] row;
    logic [11:0] col;
    logic [11:0] pair_row;
    logic [11:0] pair_col;
  } prt_pos_t;

  typedef struct packed {
    logic [15:0] fine_min;
    logic [15:0] fine_margin;
    logic [15:0] fine_corr;
    logic [15:0] min_line_len;
    logic [15:0] min_line_blank;
  } prt_lim_t;

  // Maps row speed 1/2/4 and the row binning flag onto a table index.
  function automatic logic [2:0] prt_tbl_idx(input logic [2:0] speed, input logic binned);
    logic [2:0] base;
    base = (speed == 3'h4) ? 3'h2 : (speed == 3'h2) ? 3'h1 : 3'h0;
    return binned ? 3'(base + 3'h3) : base;
  endfunction

endpackage

//--- prt_readout.sv
// Readout sequencer of the pixel array: window, orientation, subsampling and frame timing.
// Operation
// RL1: Default window gives 3840x2748; border up to 8, or 4 when binning.
// RL2: Mirror reverses column order, from window last column to first.
// RL3: Flip reverses row order, from window last row to first.
// RL4: Colour phase output follows mirror and flip of the current frame.
// RL5: Column skip up to 4x, row skip up to 32x.
// RL6: Column skip shortens active row, row skip reduces rows read.
// RL7: Summing pairs adjacent same colour; binning adjacent or every other.
// RL8: Software never uses two combining methods in one direction.
// RL9: Two axis binning only with row and column skip 2 or 4.
// RL10: Column combining needs column skip 2 or 4; no skip, no combining. sum_xy is checked against row skip only, not column skip.
// RL11: Frame period is line length ticks times frame length lines.
// RL12: Software keeps line length at or above the speed table minimum.
// RL13: Line length exceeds half column span plus minimum line blanking.
// RL14: Line length lets the output FIFO drain every row.
// RL15: Frame length at least read rows plus 0x008F blanking lines.
// RL16: Coarse integration above frame length stretches frame to coarse plus one.
// RL17: Fine integration limits reported by row speed and binning.
// RL18: Fine correction reported by row speed and binning.
// RL19: Low power doubles the pixel clock divider internally.
// RL20: Low power enables no subsampling and works in any mode.
// RL21: Software never enables low power with divider 4.
// RL22: Software reprograms limits after entering low power.
// RL23: Rows and columns walk the window; output sizes set delivered dimensions.
// RL24: New settings take effect only at the next frame start.
`timescale 1ns/1ps
module prt_readout (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Control
  input  wire logic              stream_en,
  input  wire prt_pkg::prt_cfg_t cfg,
  // Pixel stream timing
  output prt_pkg::prt_pos_t      pos,
  output logic                   frame_valid,
  output logic                   line_valid,
  output logic                   frame_start,
  // Status
  output logic [1:0]             pixel_order,
  output prt_pkg::prt_lim_t      limits,
  output logic [15:0]            frame_lines,
  output logic                   cfg_illegal
);
  import prt_pkg::*;

  typedef enum logic {PRT_IDLE, PRT_RUN} prt_state_t;

  prt_state_t  state_r;
  prt_cfg_t    act_r;
  logic [3:0]  div_cnt_r;
  logic [3:0]  eff_div_r;
  logic [15:0] row_r;
  logic [15:0] col_r;
  logic [15:0] frame_lines_r;
  prt_pos_t    pos_r;
  logic        fv_r;
  logic        lv_r;
  logic        fs_r;
  logic [1:0]  order_r;
  prt_lim_t    lim_r;
  logic        illegal_r;

  logic        tick;
  logic        line_end;
  logic        frame_end;
  logic        latch;
  logic [11:0] cols_act;
  logic [11:0] rows_act;
  logic [11:0] x_span;
  logic [11:0] y_span;
  logic [11:0] col_off;
  logic [11:0] row_off;
  logic [11:0] col_addr;
  logic [11:0] row_addr;
  logic [11:0] pair_gap;
  logic        x_comb;
  logic        y_comb;
  logic        bad_nxt;
  logic [2:0]  lim_idx;
  logic [3:0]  border;

  // ==========================================================================
  // Internal pixel clock and frame sequencing
  assign tick      = (state_r == PRT_RUN) && (div_cnt_r == 4'(eff_div_r - 4'h1));
  assign line_end  = tick && (col_r == 16'(act_r.line_len - 16'h0001));
  assign frame_end = line_end && (row_r == 16'(frame_lines_r - 16'h0001));
  assign latch     = ((state_r == PRT_IDLE) && stream_en) || frame_end; // RL24

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= PRT_IDLE;
    end else begin
      case (state_r)
        PRT_IDLE: if (stream_en) state_r <= PRT_RUN;
        PRT_RUN:  if (frame_end && !stream_en) state_r <= PRT_IDLE;
        default:  state_r <= PRT_IDLE;
      endcase
    end
  end

  // Settings are captured only at a frame boundary.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_r         <= '0;
      eff_div_r     <= 4'h1;
      frame_lines_r <= PRT_MIN_FRAME_LINES;
    end else if (latch) begin
      act_r         <= cfg; // RL24
      eff_div_r     <= cfg.low_power ? {cfg.pixel_clock_divider, 1'b0}
                                     : {1'b0, cfg.pixel_clock_divider}; // RL19 RL20
      frame_lines_r <= (cfg.coarse > cfg.frame_len) ? 16'(cfg.coarse + 16'h0001)
                                                    : cfg.frame_len; // RL16
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_r <= '0;
    end else if (latch || tick) begin
      div_cnt_r <= '0;
    end else if (state_r == PRT_RUN) begin
      div_cnt_r <= 4'(div_cnt_r + 4'h1);
    end
  end

  // Frame period is line length ticks times frame lines.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      row_r <= '0;
      col_r <= '0;
    end else if (latch) begin
      row_r <= '0;
      col_r <= '0;
    end else if (line_end) begin
      col_r <= '0; // RL11
      row_r <= 16'(row_r + 16'h0001); // RL11
    end else if (tick) begin
      col_r <= 16'(col_r + 16'h0001);
    end
  end

  // ==========================================================================
  // Address generation inside the window
  assign x_span   = 12'((12'(act_r.x_end - act_r.x_start) + 12'h001) >> act_r.skip_x_log);
  assign y_span   = 12'((12'(act_r.y_end - act_r.y_start) + 12'h001) >> act_r.skip_y_log);
  assign cols_act = (act_r.x_out < x_span) ? act_r.x_out : x_span; // RL6 RL23
  assign rows_act = (act_r.y_out < y_span) ? act_r.y_out : y_span; // RL6 RL23
  assign col_off  = 12'(col_r[11:0] << act_r.skip_x_log); // RL5
  assign row_off  = 12'(row_r[11:0] << act_r.skip_y_log); // RL5
  assign col_addr = act_r.mirror ? 12'(act_r.x_end - col_off) : 12'(act_r.x_start + col_off); // RL2
  assign row_addr = act_r.flip ? 12'(act_r.y_end - row_off) : 12'(act_r.y_start + row_off); // RL3
  assign x_comb   = act_r.bin_x | act_r.two_axis_average | act_r.sum_x | act_r.sum_xy;
  assign y_comb   = act_r.two_axis_average | act_r.sum_xy;
  // Summing always pairs the nearest same-colour pixel.
  assign pair_gap = (act_r.bin_spread && !(act_r.sum_x || act_r.sum_xy)) ? PRT_PAIR_FAR
                                                                        : PRT_PAIR_NEAR; // RL7

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_r <= '0;
    end else begin
      pos_r.row      <= row_addr;
      pos_r.col      <= col_addr;
      pos_r.pair_row <= !y_comb ? row_addr
                      : act_r.flip ? 12'(row_addr - pair_gap) : 12'(row_addr + pair_gap); // RL7
      pos_r.pair_col <= !x_comb ? col_addr
                      : act_r.mirror ? 12'(col_addr - pair_gap) : 12'(col_addr + pair_gap); // RL7
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fv_r <= 1'b0;
      lv_r <= 1'b0;
      fs_r <= 1'b0;
    end else begin
      fv_r <= (state_r == PRT_RUN) && !latch && (row_r < 16'(rows_act)); // RL23
      lv_r <= (state_r == PRT_RUN) && !latch && (row_r < 16'(rows_act))
              && (col_r < 16'(cols_act)); // RL6
      fs_r <= latch;
    end
  end

  // ==========================================================================
  // Colour phase, limits and configuration check
  assign lim_idx = prt_tbl_idx(cfg.row_speed, cfg.two_axis_average);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      order_r <= PRT_BAYER_BASE;
      lim_r   <= '0;
    end else if (latch) begin
      order_r <= PRT_BAYER_BASE ^ {cfg.flip ? cfg.y_end[0] : cfg.y_start[0],
                                   cfg.mirror ? cfg.x_end[0] : cfg.x_start[0]}; // RL4
      lim_r.fine_min       <= PRT_FINE_MIN_TBL[lim_idx]; // RL17
      lim_r.fine_margin    <= PRT_FINE_MARGIN_TBL[lim_idx]; // RL17
      lim_r.fine_corr      <= PRT_FINE_CORR_TBL[lim_idx]; // RL18
      lim_r.min_line_len   <= PRT_MIN_LINE_TBL[lim_idx];
      lim_r.min_line_blank <= PRT_MIN_BLANK_TBL[lim_idx];
    end
  end

  // Illegal settings are only flagged; the frame still runs as programmed.
  always_comb begin
    bad_nxt = 1'b0;
    border  = (cfg.bin_x || cfg.two_axis_average) ? PRT_BORDER_BIN : PRT_BORDER_MAX;
    // A window wider or taller than the default image plus a border on both edges is flagged.
    if (12'(cfg.x_end - cfg.x_start) >= 12'(PRT_DEF_X_OUT + 12'({border, 1'b0}))) // RL1
      bad_nxt = 1'b1;
    if (12'(cfg.y_end - cfg.y_start) >= 12'(PRT_DEF_Y_OUT + 12'({border, 1'b0}))) // RL1
      bad_nxt = 1'b1;
    if (cfg.skip_x_log > PRT_SKIPX_LOG_MAX || cfg.skip_y_log > PRT_SKIPY_LOG_MAX)
      bad_nxt = 1'b1;
    if ((3'(cfg.bin_x) + 3'(cfg.two_axis_average) + 3'(cfg.sum_x) + 3'(cfg.sum_xy)) > 3'h1)
      bad_nxt = 1'b1;
    if (cfg.two_axis_average && (cfg.skip_x_log == 2'h0 || cfg.skip_y_log == 3'h0
        || cfg.skip_y_log > PRT_BINXY_SKIPY_LOG_MAX))
      bad_nxt = 1'b1;
    if ((cfg.bin_x || cfg.sum_x) && cfg.skip_x_log == 2'h0)
      bad_nxt = 1'b1;
    if (cfg.sum_xy && cfg.skip_y_log == 3'h0)
      bad_nxt = 1'b1;
    if (cfg.low_power && cfg.pixel_clock_divider == PRT_ILLEGAL_LP_DIV)
      bad_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= bad_nxt;
    end
  end

  assign pos         = pos_r;
  assign frame_valid = fv_r;
  assign line_valid  = lv_r;
  assign frame_start = fs_r;
  assign pixel_order = order_r;
  assign limits      = lim_r;
  assign frame_lines = frame_lines_r;
  assign cfg_illegal = illegal_r;

  // ==========================================================================
  // Assertions
  a_mirror_first_col: assert property (@(posedge clk) disable iff (!arst_n) // RL2
    $rose(lv_r) && act_r.mirror && !fs_r |-> pos_r.col == act_r.x_end)
    else $error("mirrored row does not start at window end column");

  a_flip_first_row: assert property (@(posedge clk) disable iff (!arst_n) // RL3
    tick && row_r == 16'h0000 && col_r == 16'h0000 && act_r.flip |=> pos_r.row == act_r.y_end)
    else $error("flipped frame does not start at window end row");

  a_order_follows_orient: assert property (@(posedge clk) disable iff (!arst_n) // RL4
    latch |=> order_r[0] == (PRT_BAYER_BASE[0] ^ act_r.x_end[0]) || !act_r.mirror)
    else $error("colour phase ignores mirror");

  a_skip_col_step: assert property (@(posedge clk) disable iff (!arst_n) // RL5
    tick && !line_end && !act_r.mirror ##1 1'b1 ##1 1'b1
    |-> pos_r.col == 12'($past(pos_r.col, 1) + (12'h001 << $past(act_r.skip_x_log)))
        || $past(latch, 2))
    else $error("column step differs from skip factor");

  a_lv_within_cols: assert property (@(posedge clk) disable iff (!arst_n) // RL6
    lv_r |-> $past(col_r) < 16'($past(cols_act)))
    else $error("line valid outside active columns");

  a_frame_wraps: assert property (@(posedge clk) disable iff (!arst_n) // RL11
    frame_end |=> row_r == 16'h0000 && col_r == 16'h0000 && fs_r)
    else $error("frame does not restart after frame length lines");

  a_frame_stretch: assert property (@(posedge clk) disable iff (!arst_n) // RL16
    latch && cfg.coarse > cfg.frame_len |=> frame_lines_r == 16'($past(cfg.coarse) + 16'h0001))
    else $error("frame not stretched for long coarse integration");

  a_fine_speed1: assert property (@(posedge clk) disable iff (!arst_n) // RL17 RL18
    latch && cfg.row_speed == 3'h1 && !cfg.two_axis_average
    |=> lim_r.fine_min == 16'h03F2 && lim_r.fine_margin == 16'h027E
        && lim_r.fine_corr == 16'h009C)
    else $error("speed 1 fine limits wrong");

  a_low_power_tick: assert property (@(posedge clk) disable iff (!arst_n) // RL19
    tick && act_r.low_power && !latch ##1 !latch |-> !tick)
    else $error("low power tick not slowed");

  a_cfg_held: assert property (@(posedge clk) disable iff (!arst_n) // RL24
    !$past(latch) |-> act_r == $past(act_r))
    else $error("settings changed inside a frame");

endmodule

//--- tb.sv
// Self-checking testbench of the pixel array readout sequencer.
`timescale 1ns/1ps
module tb;
  import prt_pkg::*;
  typedef struct packed {
    logic        m;
    logic        f;
    logic        taa;
    logic        lp;
    logic [1:0]  sx;
    logic [2:0]  sy;
    logic [2:0]  spd;
    logic [2:0]  dv;
    logic [15:0] crs;
    logic [1:0]  xpo;
    logic [15:0] xfl;
  } prt_row_t;
  // Orientation, subsampling, speed, stretch and low power cases.
  localparam prt_row_t ROWS [0:7] = '{
    '{1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h0, 3'h1, 3'h1, 16'h0000, 2'h0, 16'h0093},
    '{1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 3'h0, 3'h1, 3'h1, 16'h0000, 2'h1, 16'h0093},
    '{1'h0, 1'h1, 1'h0, 1'h0, 2'h0, 3'h0, 3'h1, 3'h1, 16'h0000, 2'h2, 16'h0093},
    '{1'h1, 1'h1, 1'h0, 1'h0, 2'h0, 3'h0, 3'h1, 3'h1, 16'h0000, 2'h3, 16'h0093},
    '{1'h0, 1'h0, 1'h1, 1'h0, 2'h1, 3'h1, 3'h2, 3'h1, 16'h0000, 2'h0, 16'h0093},
    '{1'h1, 1'h1, 1'h0, 1'h0, 2'h2, 3'h2, 3'h4, 3'h1, 16'h0000, 2'h3, 16'h0093},
    '{1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h0, 3'h1, 3'h1, 16'h00A0, 2'h0, 16'h00A1},
    '{1'h0, 1'h0, 1'h0, 1'h1, 2'h0, 3'h0, 3'h1, 3'h2, 16'h0000, 2'h0, 16'h0093}};
  logic        clk;
  logic        arst_n;
  logic        stream_en;
  prt_cfg_t    cfg;
  prt_cfg_t    c;
  prt_cfg_t    cfg_base;
  prt_pos_t    pos;
  prt_pos_t    first_pos;
  prt_pos_t    last_pos;
  logic        frame_valid;
  logic        line_valid;
  logic        frame_start;
  logic        cfg_illegal;
  logic [1:0]  pixel_order;
  logic [1:0]  po;
  logic [1:0]  po_prev;
  prt_lim_t    limits;
  prt_lim_t    lim;
  logic [15:0] frame_lines;
  logic [15:0] lines_seen;
  logic [15:0] pix_seen;
  logic [15:0] fl;
  logic [31:0] period;
  logic [31:0] fv_len;
  logic [11:0] nc;
  logic [11:0] nr;
  logic [11:0] fc;
  logic [11:0] fr;
  logic [11:0] lc;
  logic [11:0] lr;
  logic [2:0]  ix;
  logic [3:0]  e;
  prt_row_t    r;
  int          err_count;
  int          compares;
  int          cycles;

  prt_readout i_dut (.clk(clk), .arst_n(arst_n), .stream_en(stream_en), .cfg(cfg),
    .pos(pos), .frame_valid(frame_valid), .line_valid(line_valid),
    .frame_start(frame_start), .pixel_order(pixel_order), .limits(limits),
    .frame_lines(frame_lines), .cfg_illegal(cfg_illegal));
  prt_host_model i_host (.clk(clk), .arst_n(arst_n), .frame_start(frame_start),
    .frame_valid(frame_valid), .line_valid(line_valid), .pos(pos),
    .lines_seen(lines_seen), .pix_seen(pix_seen), .first_pos(first_pos),
    .last_pos(last_pos), .period(period), .fv_len(fv_len));

  // ==========================================================================
  // Checking and closing
  task automatic chk_val(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val(80'(got), 80'(exp));
  endtask
  task automatic stop_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_fs();
    do @(negedge clk); while (frame_start !== 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Watchdog sized well above the longest expected run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_count++;
      stop_test();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {err_count, compares, cycles} = '0;
    arst_n = 1'b0;
    stream_en = 1'b0;
    cfg = '0;
    {cfg.x_start, cfg.x_end, cfg.x_out} = {12'h0008, 12'h000F, 12'h0008};
    {cfg.y_start, cfg.y_end, cfg.y_out} = {12'h0008, 12'h000B, 12'h0004};
    // Lines are kept far shorter than the array minimum so that every frame stays brief.
    {cfg.line_len, cfg.frame_len} = {16'h000C, 16'h0093};
    {cfg.row_speed, cfg.pixel_clock_divider} = {3'h1, 3'h1};
    repeat (3) @(negedge clk);
    chk_val(80'({frame_lines, pixel_order, frame_start}), 80'({PRT_MIN_FRAME_LINES, PRT_BAYER_BASE, 1'b0}));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    cfg_base = cfg;
    for (int j = 0; j < 6; j++) begin
      @(posedge clk);
      c = cfg_base;
      case (j)
        0: c.skip_x_log = 2'h3;
        1: {c.two_axis_average, c.sum_xy, c.skip_x_log, c.skip_y_log} = {2'h3, 2'h1, 3'h1};
        2: {c.two_axis_average, c.skip_x_log, c.skip_y_log} = {1'h1, 2'h1, 3'h3};
        3: c.bin_x = 1'b1;
        4: {c.low_power, c.pixel_clock_divider} = {1'h1, 3'h4};
        default: {c.x_start, c.x_end} = {12'h0000, 12'h0F10};
      endcase
      cfg <= c;
      repeat (2) @(negedge clk);
      chk_bit(cfg_illegal, 1'b1);
      $display("illegal case %0d done", j);
    end
    @(posedge clk);
    cfg <= cfg_base;
    stream_en <= 1'b1;
    wait_fs();
    po_prev = PRT_BAYER_BASE;
    for (int i = 0; i < 8; i++) begin
      r = ROWS[i];
      nc = 12'h0008 >> r.sx;
      nr = 12'h0004 >> r.sy;
      fc = r.m ? 12'h000F : 12'h0008;
      fr = r.f ? 12'h000B : 12'h0008;
      lc = r.m ? fc - ((nc - 12'h0001) << r.sx) : fc + ((nc - 12'h0001) << r.sx);
      lr = r.f ? fr - ((nr - 12'h0001) << r.sy) : fr + ((nr - 12'h0001) << r.sy);
      fl = r.xfl;
      e = 4'(r.dv) << r.lp;
      ix = ((r.spd == 3'h4) ? 3'h2 : (r.spd == 3'h2) ? 3'h1 : 3'h0) + (r.taa ? 3'h3 : 3'h0);
      lim = {PRT_FINE_MIN_TBL[ix], PRT_FINE_MARGIN_TBL[ix], PRT_FINE_CORR_TBL[ix],
             PRT_MIN_LINE_TBL[ix], PRT_MIN_BLANK_TBL[ix]};
      po = r.xpo;
      @(posedge clk);
      c = cfg;
      {c.mirror, c.flip, c.two_axis_average, c.low_power} = {r.m, r.f, r.taa, r.lp};
      {c.skip_x_log, c.skip_y_log, c.row_speed} = {r.sx, r.sy, r.spd};
      {c.pixel_clock_divider, c.coarse} = {r.dv, r.crs};
      {c.bin_x, c.sum_x, c.sum_xy} = 3'h0;
      cfg <= c;
      repeat (3) @(negedge clk);
      chk_val(80'(pixel_order), 80'(po_prev));
      wait_fs();
      chk_val(80'(pixel_order), 80'(po));
      chk_val(80'(frame_lines), 80'(fl));
      chk_val(80'(limits), 80'(lim));
      chk_bit(cfg_illegal, 1'b0);
      wait_fs();
      @(negedge clk);
      chk_val(80'({lines_seen, pix_seen}), 80'({16'(nr), 16'(nr * nc)}));
      chk_val(80'({first_pos.row, first_pos.col}), 80'({fr, fc}));
      chk_val(80'({first_pos.pair_row, first_pos.pair_col}),
              80'({12'(fr + (r.taa ? PRT_PAIR_NEAR : 12'h000)),
                   12'(fc + (r.taa ? PRT_PAIR_NEAR : 12'h000))}));
      chk_val(80'({last_pos.row, last_pos.col}), 80'({lr, lc}));
      chk_val(80'(period), 80'(32'(fl) * 32'h0000_000C * 32'(e)));
      chk_val(80'(fv_len), 80'(32'(nr) * 32'h0000_000C * 32'(e)));
      po_prev = po;
      $display("row %0d done", i);
    end
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chk_val(80'({frame_lines, line_valid}), 80'({PRT_MIN_FRAME_LINES, 1'b0}));
    $display("second reset done");
    stop_test();
  end
endmodule
